// ### src/dss_top.sv
// drive select and status interface: selection decode, head load and
// step gating, index/sector timing, ready and disk change status
// assumes host and drive-side inputs synchronous to pclk
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Function
// [RULE1] radial: exactly one low select line picks drive and side
// [RULE2] binary: select line 0 low enables; lines 3,2 code drive 0..3
// [RULE3] binary: select line 1 high picks side 0, low side 1
// [RULE4] standard: heads load while selected and head load requested
// [RULE5] auto strap: heads load whenever the drive is selected
// [RULE6] radial head load strap: heads load without selection
// [RULE7] default: step and direction pass only while selected
// [RULE8] radial step strap: step and direction always pass
// [RULE9] raw read line pulses low for each flux change
// [RULE10] separator fitted: separated bits and timing on own lines
// [RULE11] cylinder zero output low while heads sit on cylinder zero
// [RULE12] write protect output low and writing inhibited when protected
// [RULE13] dual side output low for two-sided, high for single-sided
// [RULE14] index pulse leads each revolution, one revolution period
// [RULE15] hard sector: low pulse per sector, 32, or 16 or 8 by strap
// [RULE16] ready only above three quarter speed after three indexes
// [RULE17] single-sided disk: ready only while side 0 selected
// [RULE18] ready loss while deselected shows disk change on next select
// [RULE19] direction low steps inward to 76, high outward to 0
// [RULE20] host drives head load request low to load heads
// [RULE21] deselected: status and data outputs held inactive high
module dss_top #(
	parameter int REV_CYCLES = dss_pkg::DSS_INDEX_CYC,
	parameter int PULSE_CYCLES = dss_pkg::DSS_PULSE_CYC,
	parameter int CW = 23
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host control lines, active low
	input wire logic [3:0] select_n,
	input wire logic head_load_req_n,
	input wire logic step_n,
	input wire logic step_in_n,
	// drive sensors and read chain
	input wire logic flux_pulse,
	input wire logic sep_bit_in,
	input wire logic sep_timing_in,
	input wire logic cyl_zero_sense,
	input wire logic wp_sense,
	input wire logic dual_side_sense,
	input wire logic disk_present,
	input wire logic speed_ok,
	// host status outputs, active low
	output logic raw_data_n,
	output logic separated_bit_n,
	output logic separated_timing_n,
	output logic cylinder_zero_n,
	output logic write_protect_n,
	output logic dual_side_n,
	output logic index_n,
	output logic sector_n,
	output logic ready_n,
	output logic disk_change_n,
	// drive mechanics
	output logic head_load,
	output logic step_pulse,
	output logic step_inward,
	output logic write_inhibit
);
	import dss_pkg::*;

	localparam int SEC32 = REV_CYCLES / DSS_SECTORS;

	typedef struct packed {
		logic [DSS_CFG_W-1:0] cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic selected;
		logic side;
		logic [CW-1:0] rev_cnt;
		logic [CW-1:0] sec_cnt;
		logic [1:0] idx_seen;
		logic ready_raw;
		logic chg_flag;
		logic raw_n;
		logic sbit_n;
		logic stim_n;
		logic cz_n;
		logic wp_n;
		logic ds_n;
		logic idx_n;
		logic sec_n;
		logic rdy_n;
		logic chg_n;
		logic heads;
		logic step;
		logic dir_in;
		logic winh;
	} dss_state_t;

	dss_state_t s;
	dss_state_t next_s;
	logic hit;
	logic side_sel;
	logic binary;
	dss_hl_t hl_mode;
	logic radial_step;
	logic [1:0] unit;
	logic [CW-1:0] sec_len;

	// ----------------------------------------
	// configuration view
	// ----------------------------------------
	assign binary = s.cfg[DSS_CFG_BINARY];
	assign hl_mode = dss_hl_t'(s.cfg[DSS_CFG_HL_LO +: 2]);
	assign radial_step = s.cfg[DSS_CFG_RSTEP];
	assign unit = s.cfg[DSS_CFG_UNIT_LO +: 2];

	always_comb begin
		case (s.cfg[DSS_CFG_SECT_LO +: 2])
			DSS_SECT_32: sec_len = CW'(SEC32);
			DSS_SECT_16: sec_len = CW'(SEC32 * 2);
			default: sec_len = CW'(SEC32 * 4);
		endcase
	end

	// ----------------------------------------
	// select decode
	// ----------------------------------------
	always_comb begin
		hit = 1'b0;
		side_sel = 1'b0;
		if (binary) begin
			if (!select_n[0]) begin
				hit = ({~select_n[3], ~select_n[2]} == unit); // RULE2
				side_sel = ~select_n[1]; // RULE3
			end
		end else begin
			case (select_n)
				4'hE: begin
					hit = !unit[0]; // RULE1
					side_sel = 1'b0;
				end
				4'hD: begin
					hit = !unit[0];
					side_sel = 1'b1;
				end
				4'hB: begin
					hit = unit[0];
					side_sel = 1'b0;
				end
				4'h7: begin
					hit = unit[0];
					side_sel = 1'b1;
				end
				default: begin
					hit = 1'b0;
					side_sel = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic idx_evt;
		logic rdy_gate;
		logic access;
		idx_evt = 1'b0;
		rdy_gate = 1'b0;
		access = 1'b0;
		next_s = s;
		next_s.selected = hit;
		next_s.side = side_sel;

		// bus slave, one wait state
		access = psel && penable && s.pready;
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = psel && penable && !s.pready
			&& paddr != DSS_CFG_OFS && paddr != DSS_STAT_OFS;
		if (access && pwrite && paddr == DSS_CFG_OFS)
			next_s.cfg = pwdata[DSS_CFG_W-1:0];
		if (psel && !penable) begin
			case (paddr)
				DSS_CFG_OFS: next_s.prdata = 32'(s.cfg);
				DSS_STAT_OFS: next_s.prdata = {21'h0, disk_present,
					s.idx_seen, wp_sense, cyl_zero_sense,
					dual_side_sense, s.chg_flag, s.ready_raw,
					s.heads, s.side, s.selected};
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end

		// revolution and sector timing
		if (!disk_present) begin
			next_s.rev_cnt = '0;
			next_s.sec_cnt = '0;
		end else begin
			idx_evt = (s.rev_cnt == '0);
			next_s.rev_cnt = (s.rev_cnt == CW'(REV_CYCLES - 1)) ? '0
				: s.rev_cnt + 1'b1; // RULE14
			next_s.sec_cnt = (s.rev_cnt == CW'(REV_CYCLES - 1)
				|| s.sec_cnt == sec_len - 1'b1) ? '0
				: s.sec_cnt + 1'b1; // RULE15
		end

		// ready monitor
		if (!disk_present || !speed_ok) begin
			next_s.idx_seen = 2'h0;
		end else if (idx_evt && s.idx_seen != DSS_READY_INDEXES) begin
			next_s.idx_seen = s.idx_seen + 1'b1;
		end
		next_s.ready_raw = disk_present && speed_ok
			&& next_s.idx_seen == DSS_READY_INDEXES; // RULE16
		rdy_gate = s.ready_raw && !(side_sel && !dual_side_sense); // RULE17

		// disk change latch, set wins over clear
		if (s.ready_raw && !next_s.ready_raw && !hit)
			next_s.chg_flag = 1'b1; // RULE18
		else if (s.selected && !hit)
			next_s.chg_flag = 1'b0;

		// host outputs
		if (hit) begin
			next_s.raw_n = !flux_pulse; // RULE9
			next_s.sbit_n = !(s.cfg[DSS_CFG_SEPFIT] && sep_bit_in); // RULE10
			next_s.stim_n = !(s.cfg[DSS_CFG_SEPFIT] && sep_timing_in);
			next_s.cz_n = !cyl_zero_sense; // RULE11
			next_s.wp_n = !wp_sense; // RULE12
			next_s.ds_n = !dual_side_sense; // RULE13
			next_s.idx_n = !(disk_present
				&& s.rev_cnt < CW'(PULSE_CYCLES)); // RULE14
			next_s.sec_n = !(s.cfg[DSS_CFG_HARDSEC] && disk_present
				&& s.sec_cnt < CW'(PULSE_CYCLES)); // RULE15
			next_s.rdy_n = !rdy_gate;
			next_s.chg_n = !s.chg_flag; // RULE18
		end else begin
			next_s.raw_n = 1'b1; // RULE21
			next_s.sbit_n = 1'b1;
			next_s.stim_n = 1'b1;
			next_s.cz_n = 1'b1;
			next_s.wp_n = 1'b1;
			next_s.ds_n = 1'b1;
			next_s.idx_n = 1'b1;
			next_s.sec_n = 1'b1;
			next_s.rdy_n = 1'b1;
			next_s.chg_n = 1'b1;
		end

		// head load
		case (hl_mode)
			DSS_HL_SELECTED: next_s.heads = hit && !head_load_req_n; // RULE4 RULE20
			DSS_HL_AUTO: next_s.heads = hit; // RULE5
			DSS_HL_RADIAL: next_s.heads = !head_load_req_n; // RULE6
			default: next_s.heads = hit && !head_load_req_n;
		endcase

		// step gating
		if (hit || radial_step) begin
			next_s.step = !step_n; // RULE7 RULE8
			next_s.dir_in = !step_in_n; // RULE19
		end else begin
			next_s.step = 1'b0; // RULE7
		end
		next_s.winh = wp_sense; // RULE12
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.cfg <= DSS_CFG_RESET;
			s.raw_n <= 1'b1;
			s.sbit_n <= 1'b1;
			s.stim_n <= 1'b1;
			s.cz_n <= 1'b1;
			s.wp_n <= 1'b1;
			s.ds_n <= 1'b1;
			s.idx_n <= 1'b1;
			s.sec_n <= 1'b1;
			s.rdy_n <= 1'b1;
			s.chg_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign raw_data_n = s.raw_n;
	assign separated_bit_n = s.sbit_n;
	assign separated_timing_n = s.stim_n;
	assign cylinder_zero_n = s.cz_n;
	assign write_protect_n = s.wp_n;
	assign dual_side_n = s.ds_n;
	assign index_n = s.idx_n;
	assign sector_n = s.sec_n;
	assign ready_n = s.rdy_n;
	assign disk_change_n = s.chg_n;
	assign head_load = s.heads;
	assign step_pulse = s.step;
	assign step_inward = s.dir_in;
	assign write_inhibit = s.winh;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking dss_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_RADIAL_DECODE: assert property ( // RULE1
		!binary && select_n == 4'hD && !unit[0]
		|=> s.selected && s.side)
		else $error("radial line 1 did not pick drive 0 side 1");
	AST_BINARY_OFF: assert property ( // RULE2
		binary && select_n[0] |=> !s.selected && head_load == 1'b0
			|| hl_mode == DSS_HL_RADIAL)
		else $error("binary select high on line 0 still selected");
	AST_BINARY_SIDE: assert property ( // RULE3
		binary && hit |=> s.side == !$past(select_n[1]))
		else $error("binary side does not follow select line 1");
	AST_HEAD_STD: assert property ( // RULE4
		hl_mode == DSS_HL_SELECTED && (head_load_req_n || !hit)
		|=> !head_load)
		else $error("heads loaded without select and request");
	AST_HEAD_AUTO: assert property ( // RULE5
		hl_mode == DSS_HL_AUTO && hit |=> head_load)
		else $error("auto head load missed a selection");
	AST_STEP_GATE: assert property ( // RULE7
		!radial_step && !hit |=> !step_pulse && $stable(step_inward))
		else $error("step passed while deselected");
	AST_STEP_RADIAL: assert property ( // RULE8
		radial_step && !step_n && !step_in_n |=> step_pulse && step_inward)
		else $error("radial step strap did not pass the step");
	AST_DESEL_IDLE: assert property ( // RULE21
		!hit |=> ready_n && index_n && raw_data_n && disk_change_n)
		else $error("status output active while deselected");
	AST_WPROT: assert property ( // RULE12
		hit && wp_sense |=> !write_protect_n && write_inhibit)
		else $error("write protect not reported");
	AST_READY_NEED: assert property ( // RULE16
		$fell(ready_n) |-> $past(s.idx_seen) == DSS_READY_INDEXES)
		else $error("ready before three index pulses");
	AST_READY_SIDE: assert property ( // RULE17
		hit && side_sel && !dual_side_sense |=> ready_n)
		else $error("ready on side 1 of single-sided disk");
	AST_CHANGE_SET: assert property ( // RULE18
		s.ready_raw && !(disk_present && speed_ok) && !hit
		|=> s.chg_flag)
		else $error("ready loss while deselected not latched");
	AST_DISK_CHANGE: assert property ( // RULE18
		s.chg_flag && hit |=> !disk_change_n)
		else $error("disk change not shown on next selection");

	COV_RADIAL_SEL: cover property (!binary && hit ##1 !head_load);
	COV_BINARY_SIDE1: cover property (binary && hit && side_sel);
	COV_READY: cover property ($fell(ready_n));
	COV_CHANGE: cover property ($fell(disk_change_n));

endmodule

`default_nettype wire

// ### src/dss_pkg.sv
// drive select and status interface: shared constants and types
// assumes a 25 MHz pclk and an apb master with 32-bit data
package dss_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] DSS_CFG_OFS = 8'h00;
	localparam logic [7:0] DSS_STAT_OFS = 8'h04;

	// ----------------------------------------
	// config field positions and reset value
	// ----------------------------------------
	localparam int DSS_CFG_BINARY = 0;
	localparam int DSS_CFG_HL_LO = 1;
	localparam int DSS_CFG_RSTEP = 3;
	localparam int DSS_CFG_SECT_LO = 4;
	localparam int DSS_CFG_HARDSEC = 6;
	localparam int DSS_CFG_SEPFIT = 7;
	localparam int DSS_CFG_UNIT_LO = 8;
	localparam int DSS_CFG_W = 10;
	localparam logic [9:0] DSS_CFG_RESET = 10'h000;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		DSS_HL_SELECTED,
		DSS_HL_AUTO,
		DSS_HL_RADIAL,
		DSS_HL_SPARE
	} dss_hl_t;

	localparam logic [1:0] DSS_SECT_32 = 2'h0;
	localparam logic [1:0] DSS_SECT_16 = 2'h1;
	localparam int DSS_SECTORS = 32;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int DSS_CLK_NS = 40;
	localparam int DSS_INDEX_PERIOD_US = 166_670;
	localparam int DSS_INDEX_CYC = DSS_INDEX_PERIOD_US * 1000 / DSS_CLK_NS;
	localparam int DSS_PULSE_US = 4;
	localparam int DSS_PULSE_CYC = DSS_PULSE_US * 1000 / DSS_CLK_NS;
	localparam logic [1:0] DSS_READY_INDEXES = 2'h3;

endpackage

// ### sim/dss_host_model.sv
// host controller model: drives select, head load and step lines
// assumes pclk from the bench; lines change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module dss_host_model (
	// clock
	input wire logic pclk,
	// host lines, active low
	output logic [3:0] select_n,
	output logic head_load_req_n,
	output logic step_n,
	output logic step_in_n
);
	initial begin
		select_n = 4'hF;
		head_load_req_n = 1'b1;
		step_n = 1'b1;
		step_in_n = 1'b1;
	end
	// ----------------------------------------
	// one set of line levels per call
	// ----------------------------------------
	task automatic put(input logic [3:0] sel, input logic hl,
		input logic st, input logic dir);
		@(posedge pclk);
		select_n <= sel;
		head_load_req_n <= hl;
		step_n <= st;
		step_in_n <= dir;
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// bench for the drive select and status block
// assumes dss_pkg, dss_top and the host model compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import dss_pkg::*;
	localparam int REV = 640;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, hl_n, st_n, in_n, raw_n, sb_n, tm_n;
	logic flux = 0, sbit = 0, stim = 0, cz = 0, wp = 0, dual = 0;
	logic present = 0, spd = 0;
	logic [3:0] sel_n;
	logic cz_n, wp_n, ds_n, ix_n, sc_n, rdy_n, dc_n;
	logic hload, spulse, sin, winh;
	int n_mismatch = 0, checked = 0, cyc = 0;
	wire logic [9:0] outs = {raw_n, sb_n, tm_n, cz_n, wp_n, ds_n,
		ix_n, sc_n, rdy_n, dc_n};
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			conclude();
		end
	end
	dss_host_model i_host (.pclk(pclk), .select_n(sel_n),
		.head_load_req_n(hl_n), .step_n(st_n), .step_in_n(in_n));
	dss_top #(.REV_CYCLES(REV), .PULSE_CYCLES(4)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .select_n(sel_n), .head_load_req_n(hl_n),
		.step_n(st_n), .step_in_n(in_n), .flux_pulse(flux),
		.sep_bit_in(sbit), .sep_timing_in(stim), .cyl_zero_sense(cz),
		.wp_sense(wp), .dual_side_sense(dual), .disk_present(present),
		.speed_ok(spd), .raw_data_n(raw_n), .separated_bit_n(sb_n),
		.separated_timing_n(tm_n), .cylinder_zero_n(cz_n),
		.write_protect_n(wp_n), .dual_side_n(ds_n), .index_n(ix_n),
		.sector_n(sc_n), .ready_n(rdy_n), .disk_change_n(dc_n),
		.head_load(hload), .step_pulse(spulse), .step_inward(sin),
		.write_inhibit(winh));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic host(input logic [3:0] s, input logic h,
		input logic st, input logic dir);
		i_host.put(s, h, st, dir);
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task automatic conclude;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		apb(0, DSS_CFG_OFS, 0);
		cmp(rd, {22'h0, DSS_CFG_RESET});
		apb(1, DSS_CFG_OFS, 32'hFFFF_FFFF);
		apb(0, DSS_CFG_OFS, 0);
		cmp(rd, 32'h0000_03FF);
		apb(0, 8'h08, 0);
		cmp({rd[31:1], err}, 32'h0000_0001);
	endtask
	task automatic t_decode;
		logic [3:0] l;
		logic s, sd;
		for (int m = 0; m < 2; m++)
			for (int u = 0; u < 4; u++)
				for (int c = 0; c < 16; c++) begin
					l = ~c[3:0];
					if (m == 0) begin
						s = $countones(l) == 1 && (l[3] | l[2]) == u[0];
						sd = l[1] | l[3];
					end else begin
						s = l[0] && ~c[3:2] == u[1:0];
						sd = l[1];
					end
					apb(1, DSS_CFG_OFS, {22'h0, u[1:0], 7'h0, m[0]});
					host(c[3:0], 1, 1, 1);
					apb(0, DSS_STAT_OFS, 0);
					cmp(rd[0], s);
					if (s) cmp(rd[1], sd);
				end
	endtask
	task automatic t_hl;
		logic e;
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 4; k++) begin
				apb(1, DSS_CFG_OFS, {29'h0, m[1:0], 1'b0});
				host(k[0] ? 4'hE : 4'hF, k[1], 1, 1);
				case (m)
					1: e = k[0];
					2: e = !k[1];
					default: e = k[0] && !k[1];
				endcase
				cmp(hload, e);
			end
	endtask
	task automatic t_step;
		for (int k = 0; k < 4; k++) begin
			apb(1, DSS_CFG_OFS, {28'h0, k[1], 3'h0});
			host(k[0] ? 4'hE : 4'hF, 1, 0, 0);
			cmp(spulse, k[0] | k[1]);
			cmp(sin, k[0] | k[1]);
			host(4'hF, 1, 1, 1);
		end
	endtask
	task automatic t_status;
		apb(1, DSS_CFG_OFS, 32'h0000_0080);
		{flux, sbit, stim, cz, wp, dual} <= 6'h3F;
		host(4'hE, 1, 1, 1);
		cmp(outs[9:4], 0);
		cmp(dc_n, 1);
		apb(1, DSS_CFG_OFS, 0);
		host(4'hE, 1, 1, 1);
		cmp({sb_n, tm_n}, 2'h3);
		host(4'hF, 1, 1, 1);
		cmp(outs, 10'h3FF);
		cmp(winh, 1);
		@(posedge pclk);
		{flux, sbit, stim, cz, wp, dual} <= 6'h0;
	endtask
	task automatic t_ready;
		int t0, n;
		logic pi, ps;
		apb(1, DSS_CFG_OFS, 32'h0000_0050);
		host(4'hE, 1, 1, 1);
		@(posedge pclk);
		present <= 1;
		spd <= 1;
		repeat (REV + REV / 2) @(posedge pclk);
		cmp(rdy_n, 1);
		repeat (2 * REV) @(posedge pclk);
		cmp(rdy_n, 0);
		for (int q = 0; q < 3; q++) begin
			apb(1, DSS_CFG_OFS, {25'h0, 1'b1, q[1:0], 4'h0});
			while (ix_n !== 1'b1) @(posedge pclk);
			while (ix_n !== 1'b0) @(posedge pclk);
			t0 = cyc;
			n = 0;
			do begin
				ps = sc_n;
				pi = ix_n;
				@(posedge pclk);
				if (ps === 1'b1 && sc_n === 1'b0) n++;
			end while (!(pi === 1'b1 && ix_n === 1'b0));
			cmp(cyc - t0, REV);
			cmp(n, DSS_SECTORS >> q);
		end
		host(4'hD, 1, 1, 1);
		cmp({rdy_n, ds_n}, 2'h3);
		host(4'hF, 1, 1, 1);
		@(posedge pclk);
		present <= 0;
		@(posedge pclk);
		present <= 1;
		host(4'hE, 1, 1, 1);
		cmp(dc_n, 0);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_decode();
		t_hl();
		t_step();
		t_status();
		t_ready();
		conclude();
	end
endmodule
`default_nettype wire
